// file: rtl/swb_params.svh
// Register map, field positions, reset values and timing of the wire master
`ifndef SWB_PARAMS_SVH
`define SWB_PARAMS_SVH

`define SWB_OFF_CFG   12'h000
`define SWB_OFF_DIV   12'h004
`define SWB_OFF_CTRL  12'h008
`define SWB_OFF_DATA  12'h00C
`define SWB_OFF_FLAGS 12'h010
`define SWB_OFF_EN    12'h014

`define SWB_CFG_RESET 8'h02
`define SWB_DIV_RESET 8'h00

`define SWB_CTRL_START 0
`define SWB_CTRL_SRA   1
`define SWB_CTRL_BBOE  2
`define SWB_CTRL_LEVEL 3
`define SWB_CTRL_ODSPC 4
`define SWB_CTRL_PRES  7

`define SWB_FL_RSTD  0
`define SWB_FL_TXE   1
`define SWB_FL_RXR   2
`define SWB_FL_SHORT 3
`define SWB_FL_LOW   4

`define SWB_LAST_BYTE 4'd7
`define SWB_LAST_BIT  4'd0
`define SWB_LAST_SRA  4'd11

// Times in microseconds; one slot tick is one microsecond
`define SWB_TICKS_PER_US 10'd1
`define SWB_TK(us) ((us) * `SWB_TICKS_PER_US)

`define SWB_STD_RST_LOW_US  10'd480
`define SWB_STD_RST_HIGH_US 10'd480
`define SWB_STD_SHORT_US    10'd5
`define SWB_STD_PRES_BEG_US 10'd15
`define SWB_STD_PRES_END_US 10'd240
`define SWB_STD_W0_US       10'd60
`define SWB_STD_SLOT_US     10'd60
`define SWB_STD_REL_US      10'd5
`define SWB_STD_SAMP_US     10'd15
`define SWB_STD_REC_US      10'd7
`define SWB_LL_REL_US       10'd8
`define SWB_LL_SAMP_US      10'd22
`define SWB_LL_REC_US       10'd14

`define SWB_OD_RST_LOW_US   10'd48
`define SWB_OD_RST_HIGH_US  10'd48
`define SWB_OD_SHORT_US     10'd1
`define SWB_OD_PRES_BEG_US  10'd2
`define SWB_OD_PRES_END_US  10'd24
`define SWB_OD_W0_US        10'd6
`define SWB_OD_SLOT_US      10'd8
`define SWB_OD_REL_US       10'd1
`define SWB_OD_SAMP_US      10'd2
`define SWB_OD_REC_US       10'd2

`endif

// file: rtl/swb_pkg.sv
// Types shared by the wire master files
package swb_pkg;

    typedef struct packed {
        logic int_pullup;
        logic overdrive;
        logic single_bit;
        logic ext_pu_en;
        logic ext_pu_mode;
        logic bit_bang;
        logic force_pres;
        logic long_line;
    } swb_cfg_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RESET,
        ST_SLOT
    } swb_state_t;

endpackage

// file: rtl/swb_slot_div.sv
// Divider that makes the one-microsecond slot tick
`timescale 1ns/1ps
module swb_slot_div #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] divisor,
    output logic              tick
);
    logic [W-1:0] cnt_reg;

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            cnt_reg <= '0;
            tick    <= 1'b0;
        end
        else if (divisor == '0)
        begin
            // Zero stops the tick altogether
            cnt_reg <= '0;
            tick    <= 1'b0;
        end
        else if (cnt_reg >= divisor - 1'b1)
        begin
            cnt_reg <= '0;
            tick    <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + 1'b1;
            tick    <= 1'b0;
        end
    end
endmodule

// file: rtl/swb_top.sv
// Single-wire bus master with APB register bank
//
// Summary of operation
// - Single-bit setting moves only data bit 0; otherwise a whole byte.
// - Data write loads transmit value and starts cycle; read gives received.
// - Single-bit mode uses bit 0 only; idle line returns 1.
// - Finished transfer sets transmit-empty flag, write 1 clears, interrupts.
// - Complete received data sets receive-ready flag, write 1 clears.
// - Line level sampled inside each slot becomes the received bit.
// - Finished bus reset sets reset-done flag, write 1 clears it.
// - Writing start-reset begins reset; hardware clears it when done.
// - Presence flag set when a slave answers during the reset.
// - Forced presence drives line low in window, presence set, except in bit-bang mode.
// - Overdrive setting picks fast slot timing, else standard timing.
// - Long-line standard timing: release 8, sample 22, recovery 14 us.
// - Normal standard timing: release 5, sample 15, recovery 7 us.
// - Divisor divides clock into slot tick; zero stops the tick.
// - Bit-bang mode: output bit 1 drives line low, 0 releases.
// - Read-only status bit shows the present pin level.
// - External pull-up output high only when enabled and idle.
// - Internal pull-up enable bit switches the on-chip pull-up.
// - Short on the pin sets line-short flag, write 1 clears.
// - Pin found low sets line-low flag, write 1 clears.
// - Five flags, enables at same bits; interrupt when both set.
// - Bytes go out least significant bit first, one slot each.
// - Search mode: four bits, each read, read complement, write.
// - Search result low nibble holds discrepancy flag per bit.
`timescale 1ns/1ps
`include "swb_params.svh"
module swb_top
    import swb_pkg::*;
#(
    parameter logic OD_SPEC_VERSION = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        bus_pin_i,
    output logic             bus_pin_o,
    output logic             bus_pin_oe_n,
    output logic             ext_pullup_o,
    output logic             int_pullup_en_o,
    output logic             irq_o
);
    swb_cfg_t   cfg_reg;
    swb_state_t state_reg;
    logic [7:0] div_reg;
    logic       sra_reg;
    logic       bboe_reg;
    logic       start_reg;
    logic       presence_reg;
    logic       pres_seen_reg;
    logic [7:0] tx_reg;
    logic [7:0] rx_reg;
    logic [4:0] flag_reg;
    logic [4:0] en_reg;
    logic [9:0] cnt_reg;
    logic [3:0] slot_reg;
    logic [1:0] sub_reg;
    logic [1:0] grp_reg;
    logic       r0_reg;
    logic       chosen_reg;
    logic       op_sra_reg;
    logic       op_sbm_reg;
    logic [31:0] rd_data;
    logic        unmapped;
    logic        tick;
    logic        setup;
    logic        wr;
    logic        idle;
    logic        go_slot;
    logic        go_rst;
    logic        at_sample;
    logic        slot_end;
    logic        last_slot;
    logic        op_done;
    logic        rst_end;
    logic        short_chk;
    logic        cur_bit;
    logic        drive_next;
    logic        disc;
    logic [4:0]  flag_set;
    logic [4:0]  flag_clr;
    logic [9:0]  t_rlow;
    logic [9:0]  t_rhigh;
    logic [9:0]  t_short;
    logic [9:0]  t_pbeg;
    logic [9:0]  t_pend;
    logic [9:0]  t_w0;
    logic [9:0]  t_slot;
    logic [9:0]  t_rel;
    logic [9:0]  t_samp;
    logic [9:0]  t_rec;

    swb_slot_div #(
        .W (8)
    ) u_div (
        .clk     (clk),
        .resetn  (resetn),
        .divisor (div_reg),
        .tick    (tick)
    );

    always_comb
    begin
        if (cfg_reg.overdrive)
        begin
            t_rlow  = `SWB_TK(`SWB_OD_RST_LOW_US);
            t_rhigh = `SWB_TK(`SWB_OD_RST_HIGH_US);
            t_short = `SWB_TK(`SWB_OD_SHORT_US);
            t_pbeg  = `SWB_TK(`SWB_OD_PRES_BEG_US);
            t_pend  = `SWB_TK(`SWB_OD_PRES_END_US);
            t_w0    = `SWB_TK(`SWB_OD_W0_US);
            t_slot  = `SWB_TK(`SWB_OD_SLOT_US);
            t_rel   = `SWB_TK(`SWB_OD_REL_US);
            t_samp  = `SWB_TK(`SWB_OD_SAMP_US);
            t_rec   = `SWB_TK(`SWB_OD_REC_US);
        end
        else
        begin
            t_rlow  = `SWB_TK(`SWB_STD_RST_LOW_US);
            t_rhigh = `SWB_TK(`SWB_STD_RST_HIGH_US);
            t_short = `SWB_TK(`SWB_STD_SHORT_US);
            t_pbeg  = `SWB_TK(`SWB_STD_PRES_BEG_US);
            t_pend  = `SWB_TK(`SWB_STD_PRES_END_US);
            t_w0    = `SWB_TK(`SWB_STD_W0_US);
            t_slot  = `SWB_TK(`SWB_STD_SLOT_US);
            if (cfg_reg.long_line)
            begin
                t_rel  = `SWB_TK(`SWB_LL_REL_US);
                t_samp = `SWB_TK(`SWB_LL_SAMP_US);
                t_rec  = `SWB_TK(`SWB_LL_REC_US);
            end
            else
            begin
                t_rel  = `SWB_TK(`SWB_STD_REL_US);
                t_samp = `SWB_TK(`SWB_STD_SAMP_US);
                t_rec  = `SWB_TK(`SWB_STD_REC_US);
            end
        end
    end

    assign setup   = psel && !penable;
    assign wr      = psel && penable && pready && pwrite;
    assign idle    = (state_reg == ST_IDLE);
    // A second start while busy is dropped, not queued
    assign go_slot = wr && idle && (paddr == `SWB_OFF_DATA);
    assign go_rst  = wr && idle && (paddr == `SWB_OFF_CTRL)
                     && pwdata[`SWB_CTRL_START];
    assign at_sample = tick && (state_reg == ST_SLOT) && (cnt_reg == t_samp);
    assign slot_end  = tick && (state_reg == ST_SLOT)
                       && (cnt_reg == t_slot + t_rec);
    assign rst_end   = tick && (state_reg == ST_RESET)
                       && (cnt_reg == t_rlow + t_rhigh);
    assign short_chk = tick && (state_reg == ST_RESET)
                       && (cnt_reg == t_rlow + t_short);
    assign last_slot = op_sra_reg ? (slot_reg == `SWB_LAST_SRA) :
                       op_sbm_reg ? (slot_reg == `SWB_LAST_BIT) :
                                    (slot_reg == `SWB_LAST_BYTE);
    assign op_done   = slot_end && last_slot;
    assign disc      = (r0_reg == bus_pin_i);

    always_comb
    begin
        if (op_sra_reg)
            cur_bit = (sub_reg == 2'd2) ? chosen_reg : 1'b1;
        else if (op_sbm_reg)
            cur_bit = tx_reg[0];
        else
            cur_bit = tx_reg[slot_reg[2:0]];
    end

    always_comb
    begin
        drive_next = 1'b0;
        if (cfg_reg.bit_bang)
            drive_next = bboe_reg;
        else
        begin
            case (state_reg)
                ST_RESET:
                    drive_next = (cnt_reg < t_rlow)
                        || (cfg_reg.force_pres
                            && (cnt_reg >= t_rlow + t_pbeg)
                            && (cnt_reg < t_rlow + t_pend));
                ST_SLOT:
                    drive_next = cnt_reg < (cur_bit ? t_rel : t_w0);
                default:
                    drive_next = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            bus_pin_oe_n    <= 1'b1;
            bus_pin_o       <= 1'b0;
            ext_pullup_o    <= 1'b0;
            int_pullup_en_o <= 1'b0;
        end
        else
        begin
            bus_pin_oe_n    <= !drive_next;
            bus_pin_o       <= 1'b0;
            // Strong pull-up only between operations, never mid-slot
            ext_pullup_o    <= cfg_reg.ext_pu_en && idle
                               && !go_slot && !go_rst;
            int_pullup_en_o <= cfg_reg.int_pullup;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            state_reg <= ST_IDLE;
        else
        begin
            case (state_reg)
                ST_IDLE:
                    if (go_rst)
                        state_reg <= ST_RESET;
                    else if (go_slot)
                        state_reg <= ST_SLOT;
                ST_RESET:
                    if (rst_end)
                        state_reg <= ST_IDLE;
                ST_SLOT:
                    if (op_done)
                        state_reg <= ST_IDLE;
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            cnt_reg <= 10'h000;
        else if (go_slot || go_rst || slot_end || rst_end)
            cnt_reg <= 10'h000;
        else if (tick && !idle)
            cnt_reg <= cnt_reg + 10'h001;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            slot_reg   <= 4'h0;
            sub_reg    <= 2'h0;
            grp_reg    <= 2'h0;
            op_sra_reg <= 1'b0;
            op_sbm_reg <= 1'b0;
        end
        else if (go_slot)
        begin
            slot_reg   <= 4'h0;
            sub_reg    <= 2'h0;
            grp_reg    <= 2'h0;
            op_sra_reg <= sra_reg;
            op_sbm_reg <= cfg_reg.single_bit && !sra_reg;
        end
        else if (slot_end && !last_slot)
        begin
            slot_reg <= slot_reg + 4'h1;
            sub_reg  <= (sub_reg == 2'd2) ? 2'd0 : sub_reg + 2'd1;
            if (sub_reg == 2'd2)
                grp_reg <= grp_reg + 2'd1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            rx_reg     <= 8'h00;
            r0_reg     <= 1'b0;
            chosen_reg <= 1'b0;
        end
        else if (go_slot)
            rx_reg <= 8'h00;
        else if (at_sample)
        begin
            if (op_sra_reg)
            begin
                if (sub_reg == 2'd0)
                    r0_reg <= bus_pin_i;
                else if (sub_reg == 2'd1)
                begin
                    // On conflict follow the written guess, else the slaves
                    chosen_reg <= disc ? tx_reg[grp_reg] : r0_reg;
                    rx_reg[grp_reg] <= disc;
                    rx_reg[{1'b1, grp_reg}] <= disc ? tx_reg[grp_reg]
                                                    : r0_reg;
                end
            end
            else if (op_sbm_reg)
                rx_reg <= {7'h00, bus_pin_i};
            else
                rx_reg[slot_reg[2:0]] <= bus_pin_i;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            start_reg     <= 1'b0;
            presence_reg  <= 1'b0;
            pres_seen_reg <= 1'b0;
        end
        else if (go_rst)
        begin
            start_reg     <= 1'b1;
            presence_reg  <= 1'b0;
            pres_seen_reg <= 1'b0;
        end
        else if (rst_end)
        begin
            start_reg    <= 1'b0;
            presence_reg <= pres_seen_reg;
        end
        else if ((state_reg == ST_RESET) && (cnt_reg >= t_rlow + t_pbeg)
                 && (cnt_reg < t_rlow + t_pend) && !bus_pin_i)
            pres_seen_reg <= 1'b1;
    end

    always_comb
    begin
        flag_set = 5'h00;
        flag_set[`SWB_FL_RSTD]  = rst_end;
        flag_set[`SWB_FL_TXE]   = op_done;
        flag_set[`SWB_FL_RXR]   = op_done;
        flag_set[`SWB_FL_SHORT] = short_chk && !bus_pin_i;
        flag_set[`SWB_FL_LOW]   = (go_slot || go_rst) && !bus_pin_i;
        flag_clr = (wr && (paddr == `SWB_OFF_FLAGS)) ? pwdata[4:0] : 5'h00;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            flag_reg <= 5'h00;
        else
            flag_reg <= (flag_reg & ~flag_clr) | flag_set;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            irq_o <= 1'b0;
        else
            irq_o <= |(flag_reg & en_reg);
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            cfg_reg  <= swb_cfg_t'(`SWB_CFG_RESET);
            div_reg  <= `SWB_DIV_RESET;
            sra_reg  <= 1'b0;
            bboe_reg <= 1'b0;
            tx_reg   <= 8'h00;
            en_reg   <= 5'h00;
        end
        else if (wr)
        begin
            if (paddr == `SWB_OFF_CFG)
                cfg_reg <= swb_cfg_t'(pwdata[7:0]);
            else if (paddr == `SWB_OFF_DIV)
                div_reg <= pwdata[7:0];
            else if (paddr == `SWB_OFF_CTRL)
            begin
                sra_reg  <= pwdata[`SWB_CTRL_SRA];
                bboe_reg <= pwdata[`SWB_CTRL_BBOE];
            end
            else if (paddr == `SWB_OFF_DATA && idle)
                tx_reg <= pwdata[7:0];
            else if (paddr == `SWB_OFF_EN)
                en_reg <= pwdata[4:0];
        end
    end

    always_comb
    begin
        rd_data  = 32'h0000_0000;
        unmapped = 1'b0;
        if (paddr == `SWB_OFF_CFG)
            rd_data[7:0] = cfg_reg;
        else if (paddr == `SWB_OFF_DIV)
            rd_data[7:0] = div_reg;
        else if (paddr == `SWB_OFF_CTRL)
        begin
            rd_data[`SWB_CTRL_START] = start_reg;
            rd_data[`SWB_CTRL_SRA]   = sra_reg;
            rd_data[`SWB_CTRL_BBOE]  = bboe_reg;
            rd_data[`SWB_CTRL_LEVEL] = bus_pin_i;
            rd_data[`SWB_CTRL_ODSPC] = OD_SPEC_VERSION;
            rd_data[`SWB_CTRL_PRES]  = presence_reg;
        end
        else if (paddr == `SWB_OFF_DATA)
            rd_data[7:0] = rx_reg;
        else if (paddr == `SWB_OFF_FLAGS)
            rd_data[4:0] = flag_reg;
        else if (paddr == `SWB_OFF_EN)
            rd_data[4:0] = en_reg;
        else
            unmapped = 1'b1;
    end

    // Read data is captured in setup, so every access has no wait state
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup && unmapped;
            if (setup)
                prdata <= pwrite ? 32'h0000_0000 : rd_data;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_bitbang_pin: assert property (
        cfg_reg.bit_bang && $past(cfg_reg.bit_bang)
        |-> bus_pin_oe_n == !$past(bboe_reg))
        else $error("bit-bang output does not steer the pin");
    a_txe_done: assert property (
        op_done |=> flag_reg[`SWB_FL_TXE] && idle)
        else $error("transmit-empty not set at end of transfer");
    a_rxr_done: assert property (
        op_done |=> ##1 irq_o == en_reg[`SWB_FL_RXR] || irq_o)
        else $error("receive-ready did not reach interrupt");
    a_rst_done: assert property (
        rst_end |=> flag_reg[`SWB_FL_RSTD] && !start_reg)
        else $error("reset done flag or start bit wrong");
    a_start_hold: assert property (
        go_rst |=> start_reg throughout (state_reg == ST_RESET)[*8])
        else $error("start bit dropped during reset");
    a_force_pres: assert property (
        rst_end && cfg_reg.force_pres && !cfg_reg.bit_bang
        |=> presence_reg)
        else $error("forced presence not reported");
    a_ext_pu_idle: assert property (
        ext_pullup_o |-> $past(idle) && $past(cfg_reg.ext_pu_en))
        else $error("external pull-up high while busy");
    a_irq_gate: assert property (
        (flag_reg & en_reg) == 5'h00 |=> !irq_o)
        else $error("interrupt without enabled flag");
    a_byte_len: assert property (
        op_done && !op_sra_reg && !op_sbm_reg |-> slot_reg == 4'd7)
        else $error("byte transfer not eight slots");
    a_sra_len: assert property (
        op_done && op_sra_reg |-> slot_reg == 4'd11 && grp_reg == 2'd3)
        else $error("search step not twelve slots");
    a_level_read: assert property (
        setup && !pwrite && paddr == `SWB_OFF_CTRL
        |=> prdata[`SWB_CTRL_LEVEL] == $past(bus_pin_i))
        else $error("pin level status wrong");
    a_w1c_set_wins: assert property (
        op_done && flag_clr[`SWB_FL_TXE] |=> flag_reg[`SWB_FL_TXE])
        else $error("clear beat a new transmit-empty event");

    c_byte_done: cover property (op_done && !op_sra_reg && !op_sbm_reg);
    c_bit_done: cover property (op_done && op_sbm_reg);
    c_sra_done: cover property (op_done && op_sra_reg);
    c_reset_pres: cover property (rst_end && pres_seen_reg);
endmodule

// file: tb/swb_slave_model.sv
// Slave model on the shared wire: answers each slot with a reply bit
`timescale 1ns/1ps
module swb_slave_model (
    input  wire logic       clk,
    input  wire logic       wire_lvl,
    input  wire logic       en,
    input  wire logic [7:0] reply,
    output logic            pull_low
);
    logic [7:0] bits_reg;
    logic [9:0] hold_reg;
    logic       last_reg;

    // Hold of 30 ticks covers both sample points at one tick per clock
    always_ff @(posedge clk)
    begin
        last_reg <= wire_lvl;
        if (!en)
        begin
            bits_reg <= reply;
            hold_reg <= 10'h000;
        end
        else if (hold_reg != 10'h000)
            hold_reg <= hold_reg - 10'h001;
        else if (last_reg && !wire_lvl)
        begin
            if (!bits_reg[0])
                hold_reg <= 10'h01E;
            bits_reg <= {1'b1, bits_reg[7:1]};
        end
    end

    // Released wire falls back to the pull-up level
    assign pull_low = en && (hold_reg != 10'h000);
endmodule

// file: tb/single_wire_bus_master_tb_top.sv
// Bench for the wire master: APB driver, reference model and checks
`timescale 1ns/1ps
`include "swb_params.svh"
module single_wire_bus_master_tb_top
    import swb_pkg::*;
;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, pin_o, pin_oe_n, ext_pu, int_pu, irq;
    logic        slv_en = 1'b0;
    logic [7:0]  slv_reply = 8'hFF;
    logic        slv_low, wire_lvl;
    logic [7:0]  lfsr = 8'h35;
    int          failures = 0;
    int          total_checks = 0;

    always #5 clk = ~clk;

    assign wire_lvl = !((!pin_oe_n && !pin_o) || slv_low);

    swb_top uut (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_pin_i(wire_lvl), .bus_pin_o(pin_o),
        .bus_pin_oe_n(pin_oe_n), .ext_pullup_o(ext_pu),
        .int_pullup_en_o(int_pu), .irq_o(irq));

    swb_slave_model slave (.clk(clk), .wire_lvl(wire_lvl), .en(slv_en),
        .reply(slv_reply), .pull_low(slv_low));

    function automatic logic [7:0] next_lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    task automatic stop_test;
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Entered just after an edge; ends one idle edge after the access
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 50)
            failures++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        logic e;
        apb(1'b0, a, 32'h0, q, e);
    endtask

    // Polls flags; a bounded poll keeps a dead divider from hanging
    task automatic wait_flag(input int b);
        logic [31:0] q;
        int          n;
        q = 32'h0;
        n = 0;
        while (q[b] !== 1'b1 && n < 1000)
        begin
            rd(`SWB_OFF_FLAGS, q);
            n++;
        end
        if (n >= 1000)
            failures++;
    endtask

    initial
    begin
        #300000;
        failures++;
        stop_test();
    end

    initial
    begin
        logic [31:0] q;
        logic        e;
        logic [7:0]  tx;
        logic [11:0] s;
        logic [7:0]  ex;
        swb_cfg_t    cfg;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(`SWB_OFF_CFG, q);
        chk(q, 32'h0000_0002);
        rd(`SWB_OFF_DIV, q);
        chk(q, 32'h0);
        apb(1'b0, 12'h018, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        wr(`SWB_OFF_DIV, 32'h1);
        for (int f = 0; f < 2; f++)
        begin
            cfg = '0;
            cfg.force_pres = f[0];
            wr(`SWB_OFF_CFG, {24'h0, cfg});
            wr(`SWB_OFF_CTRL, 32'h1);
            wait_flag(`SWB_FL_RSTD);
            rd(`SWB_OFF_CTRL, q);
            chk(q & 32'h89, {24'h0, f[0], 7'h08});
            wr(`SWB_OFF_FLAGS, 32'h1);
            rd(`SWB_OFF_FLAGS, q);
            chk(q, 32'h0);
        end
        wr(`SWB_OFF_EN, 32'h6);
        for (int i = 0; i < 6; i++)
        begin
            lfsr = next_lfsr(lfsr);
            tx = (i == 0 || i == 3) ? 8'hFF : ((i == 4) ? 8'hFE : lfsr);
            cfg = '0;
            cfg.long_line = i[0];
            cfg.single_bit = (i == 3 || i == 4);
            cfg.overdrive = (i == 5);
            cfg.ext_pu_en = 1'b1;
            cfg.int_pullup = 1'b1;
            wr(`SWB_OFF_CFG, {24'h0, cfg});
            // No slave answers in the later runs, so the wire reads back the written bits
            slv_reply <= (i < 3) ? next_lfsr(lfsr) : 8'hFF;
            @(posedge clk);
            chk({31'h0, ext_pu}, 32'h1);
            chk({31'h0, int_pu}, 32'h1);
            slv_en <= (i < 3);
            wr(`SWB_OFF_DATA, {24'h0, tx});
            chk({31'h0, ext_pu}, 32'h0);
            wait_flag(`SWB_FL_RXR);
            rd(`SWB_OFF_FLAGS, q);
            chk(q, 32'h6);
            chk({31'h0, irq}, 32'h1);
            rd(`SWB_OFF_DATA, q);
            if (cfg.single_bit)
                chk(q, {31'h0, tx[0]});
            else
                chk(q, {24'h0, tx & slv_reply});
            slv_en <= 1'b0;
            wr(`SWB_OFF_FLAGS, 32'h6);
            rd(`SWB_OFF_FLAGS, q);
            chk(q, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        // Search step: reads come from the slave, ones after its eight bits
        wr(`SWB_OFF_CFG, 32'h0);
        wr(`SWB_OFF_CTRL, 32'h2);
        lfsr = next_lfsr(lfsr);
        slv_reply <= lfsr;
        tx = next_lfsr(lfsr);
        @(posedge clk);
        slv_en <= 1'b1;
        wr(`SWB_OFF_DATA, {24'h0, tx});
        wait_flag(`SWB_FL_RXR);
        rd(`SWB_OFF_DATA, q);
        s = {4'hF, lfsr};
        ex = 8'h00;
        for (int g = 0; g < 4; g++)
        begin
            ex[g] = (s[3*g] == s[3*g+1]);
            ex[4+g] = ex[g] ? tx[g] : s[3*g];
        end
        chk(q, {24'h0, ex});
        slv_en <= 1'b0;
        wr(`SWB_OFF_FLAGS, 32'h6);
        cfg = '0;
        cfg.bit_bang = 1'b1;
        wr(`SWB_OFF_CFG, {24'h0, cfg});
        wr(`SWB_OFF_CTRL, 32'h4);
        rd(`SWB_OFF_CTRL, q);
        chk(q & 32'h0C, 32'h4);
        chk({30'h0, pin_o, pin_oe_n}, 32'h0);
        // Held-low wire during a bus reset: low, short and presence seen
        wr(`SWB_OFF_CTRL, 32'h5);
        wait_flag(`SWB_FL_RSTD);
        rd(`SWB_OFF_CTRL, q);
        chk(q & 32'h81, 32'h80);
        rd(`SWB_OFF_FLAGS, q);
        chk(q, 32'h19);
        wr(`SWB_OFF_CTRL, 32'h0);
        rd(`SWB_OFF_CTRL, q);
        chk(q & 32'h0C, 32'h8);
        stop_test();
    end
endmodule
